// ### hw/switch_global_control_bits.v
// Global control bits of the switch, AXI4-Lite slave with strap-loaded defaults
// Functional notes
// - Aging bit enables address-table aging, strapped default
// - Fast-age bit ages at 800 us
// - Bit 0 selects aggressive half-duplex backoff
// - Bit 7 blocks all port-VLAN crossing
// - Bit 6 excludes multicast from storm counting
// - Bit 5 selects carrier-sense or collision backpressure
// - Fair mode drops non-flow-controlled port frames
// - Bit 3 retries after 16 collisions, strapped
// - Huge bit accepts 1916 bytes, overrides size
// - Legal-size disable accepts 1536, else 1522/1518
// - After fast cycle, normal 375 second period
`timescale 1ns/1ps
`include "switch_global_consts.vh"
module switch_global_control_bits #(
   // 34 bits: the normal period in cycles does not fit in 32
   parameter [33:0] FAST_AGE_CYCLES = `FAST_AGE_US * (`CLK_HZ / `US_PER_S),
   parameter [33:0] NORMAL_AGE_CYCLES = `NORMAL_AGE_S * `CLK_HZ
) (
   input wire clock,
   input wire srst,
   input wire [`ADDR_W-1:0] s_axi_awaddr,
   input wire s_axi_awvalid,
   output reg s_axi_awready,
   input wire [`DATA_W-1:0] s_axi_wdata,
   input wire [3:0] s_axi_wstrb,
   input wire s_axi_wvalid,
   output reg s_axi_wready,
   output reg [1:0] s_axi_bresp,
   output reg s_axi_bvalid,
   input wire s_axi_bready,
   input wire [`ADDR_W-1:0] s_axi_araddr,
   input wire s_axi_arvalid,
   output reg s_axi_arready,
   output reg [`DATA_W-1:0] s_axi_rdata,
   output reg [1:0] s_axi_rresp,
   output reg s_axi_rvalid,
   input wire s_axi_rready,
   input wire aging_strap_pin,
   input wire backoff_strap_pin,
   input wire collision_drop_strap_pin,
   input wire portVlanBoundary,
   input wire frameIsKnownUnicast,
   input wire frameIsMulticast,
   input wire frameIsBroadcast,
   input wire [10:0] frameLength,
   input wire frameTagged,
   input wire [4:0] collisionCount,
   input wire egressContention,
   output reg agingRun,
   output reg agingTick,
   output reg aggressiveBackoff,
   output reg carrierSenseBackpressure,
   output reg forwardAllowed,
   output reg stormCount,
   output reg frameOversize,
   output reg retryFrame,
   output reg dropNonFlowControlled,
   output reg flowControlPort
);

   reg [7:0] ctrlOne;
   reg [7:0] ctrlTwo;
   reg [2:0] strapMeta;
   reg [2:0] strapSync;
   reg inReset;
   reg haveAw;
   reg haveW;
   reg [`ADDR_W-1:0] awAddr;
   reg [`DATA_W-1:0] wData;
   reg [3:0] wStrb;
   reg [33:0] ageCount;
   reg fastActive;
   reg [10:0] sizeLimit;

   // Word index decode, shared by both channels
   function [7:0] regIndex;
      input [`ADDR_W-1:0] addr;
      begin
         regIndex = {2'h0, addr[`ADDR_W-1:2]};
      end
   endfunction

   // Strap pins come from outside, two stages before use
   always @(posedge clock) begin
      strapMeta <= {aging_strap_pin, backoff_strap_pin, collision_drop_strap_pin};
      strapSync <= strapMeta;
      inReset <= srst;
   end

   wire writeFire = haveAw && haveW && !s_axi_bvalid;
   wire writeOne = writeFire && (regIndex(awAddr) == `IDX_CTRL_ONE) && wStrb[0];
   wire writeTwo = writeFire && (regIndex(awAddr) == `IDX_CTRL_TWO) && wStrb[0];

   // Write channel: address and data taken in either order
   always @(posedge clock) begin
      if (srst) begin
         s_axi_awready <= 1'b1;
         s_axi_wready <= 1'b1;
         haveAw <= 1'b0;
         haveW <= 1'b0;
         awAddr <= 8'h00;
         wData <= 32'h00000000;
         wStrb <= 4'h0;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= `RESP_OKAY;
      end else begin
         if (s_axi_awvalid && s_axi_awready) begin
            haveAw <= 1'b1;
            awAddr <= s_axi_awaddr;
            s_axi_awready <= 1'b0;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            haveW <= 1'b1;
            wData <= s_axi_wdata;
            wStrb <= s_axi_wstrb;
            s_axi_wready <= 1'b0;
         end
         if (writeFire) begin
            haveAw <= 1'b0;
            haveW <= 1'b0;
            s_axi_bvalid <= 1'b1;
            if (regIndex(awAddr) == `IDX_CTRL_ONE || regIndex(awAddr) == `IDX_CTRL_TWO)
               s_axi_bresp <= `RESP_OKAY;
            else
               s_axi_bresp <= `RESP_SLVERR;
         end
         if (s_axi_bvalid && s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
            s_axi_awready <= 1'b1;
            s_axi_wready <= 1'b1;
         end
      end
   end

   // Registers; strapped bits take the pin level in the first cycle after reset is released
   always @(posedge clock) begin
      if (srst) begin
         ctrlOne <= `C1_RESET;
         ctrlTwo <= `C2_RESET;
      end else if (inReset) begin
         ctrlOne[`C1_AGING] <= strapSync[2];
         ctrlOne[`C1_BACKOFF] <= strapSync[1];
         ctrlTwo[`C2_NOCOLLDROP] <= strapSync[0];
      end else begin
         if (writeOne)
            ctrlOne <= wData[7:0];
         // fast age self-clears when the fast age period runs out
         else if (fastActive && ageCount == 34'h000000000)
            ctrlOne[`C1_FASTAGE] <= 1'b0;
         if (writeTwo)
            ctrlTwo <= wData[7:0];
      end
   end

   // Read channel, one cycle answer
   always @(posedge clock) begin
      if (srst) begin
         s_axi_arready <= 1'b1;
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= 32'h00000000;
         s_axi_rresp <= `RESP_OKAY;
      end else if (s_axi_arvalid && s_axi_arready) begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid <= 1'b1;
         s_axi_rresp <= `RESP_OKAY;
         case (regIndex(s_axi_araddr))
            `IDX_CTRL_ONE: s_axi_rdata <= {24'h000000, ctrlOne};
            `IDX_CTRL_TWO: s_axi_rdata <= {24'h000000, ctrlTwo};
            `IDX_STATUS: s_axi_rdata <= {30'h00000000, agingRun, fastActive};
            default: begin
               s_axi_rdata <= 32'h00000000;
               s_axi_rresp <= `RESP_SLVERR;
            end
         endcase
      end else if (s_axi_rvalid && s_axi_rready) begin
         s_axi_rvalid <= 1'b0;
         s_axi_arready <= 1'b1;
      end
   end

   // Age period timer; restarted on entering fast mode
   always @(posedge clock) begin
      if (srst || inReset) begin
         ageCount <= NORMAL_AGE_CYCLES - 34'd1;
         fastActive <= 1'b0;
         agingTick <= 1'b0;
         agingRun <= 1'b0;
      end else begin
         agingRun <= ctrlOne[`C1_AGING];
         agingTick <= 1'b0;
         if (!ctrlOne[`C1_AGING]) begin
            ageCount <= NORMAL_AGE_CYCLES - 34'd1;
            fastActive <= 1'b0;
         end else if (ctrlOne[`C1_FASTAGE] && !fastActive) begin
            fastActive <= 1'b1;
            ageCount <= FAST_AGE_CYCLES - 34'd1;
         end else if (ageCount == 34'h000000000) begin
            agingTick <= 1'b1;
            fastActive <= 1'b0;
            ageCount <= NORMAL_AGE_CYCLES - 34'd1;
         end else
            ageCount <= ageCount - 34'd1;
      end
   end

   always @* begin
      if (ctrlTwo[`C2_HUGE])
         sizeLimit = `SIZE_HUGE;
      else if (ctrlTwo[`C2_LEGALOFF])
         sizeLimit = `SIZE_LEGALOFF;
      else if (frameTagged)
         sizeLimit = `SIZE_TAGGED;
      else
         sizeLimit = `SIZE_UNTAGGED;
   end

   // Registered qualifiers for the forwarding and MAC logic outside
   always @(posedge clock) begin
      if (srst) begin
         aggressiveBackoff <= 1'b0;
         carrierSenseBackpressure <= 1'b1;
         forwardAllowed <= 1'b0;
         stormCount <= 1'b0;
         frameOversize <= 1'b0;
         retryFrame <= 1'b0;
         dropNonFlowControlled <= 1'b0;
         flowControlPort <= 1'b0;
      end else begin
         aggressiveBackoff <= ctrlOne[`C1_BACKOFF];
         carrierSenseBackpressure <= ctrlTwo[`C2_BPMODE];
         forwardAllowed <= !portVlanBoundary ||
            (!ctrlTwo[`C2_VLANDISCARD] && frameIsKnownUnicast);
         stormCount <= frameIsBroadcast ||
            (frameIsMulticast && !ctrlTwo[`C2_MCASTEXCL]);
         frameOversize <= frameLength > sizeLimit;
         retryFrame <= (collisionCount < `COLL_LIMIT) || ctrlTwo[`C2_NOCOLLDROP];
         dropNonFlowControlled <= egressContention && ctrlTwo[`C2_FAIR];
         flowControlPort <= egressContention && !ctrlTwo[`C2_FAIR];
      end
   end

endmodule // switch_global_control_bits

// ### hw/switch_global_consts.vh
// Register map, field positions and timing constants of the global control bits
`ifndef SWITCH_GLOBAL_CONSTS_VH
`define SWITCH_GLOBAL_CONSTS_VH
// Printed register indices; byte address is four times the index
`define IDX_CTRL_ONE 8'h03
`define IDX_CTRL_TWO 8'h04
`define IDX_STATUS 8'h05
`define ADDR_W 8
`define DATA_W 32
// global_control_one fields
`define C1_AGING 2
`define C1_FASTAGE 1
`define C1_BACKOFF 0
// global_control_two fields
`define C2_VLANDISCARD 7
`define C2_MCASTEXCL 6
`define C2_BPMODE 5
`define C2_FAIR 4
`define C2_NOCOLLDROP 3
`define C2_HUGE 2
`define C2_LEGALOFF 1
// Reset values (strapped bits are filled from pins at release)
`define C1_RESET 8'h00
`define C2_RESET 8'hF0
// Status register fields
`define ST_FASTACTIVE 0
`define ST_AGINGRUN 1
// Frame size limits in bytes
`define SIZE_HUGE 11'h77C
`define SIZE_LEGALOFF 11'h600
`define SIZE_TAGGED 11'h5F2
`define SIZE_UNTAGGED 11'h5EE
`define COLL_LIMIT 5'h10
// Timing: 40 MHz clock
`define CLK_HZ 40000000
`define US_PER_S 1000000
`define FAST_AGE_US 800
`define NORMAL_AGE_S 375
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2
`endif

// ### testbench/switch_global_control_bits_props.sv
// Checker for the forwarding, storm, size, retry and fairness qualifier outputs of the global control bits
`timescale 1ns/1ps
module switch_global_control_bits_props (
   input wire clock,
   input wire srst,
   input wire portVlanBoundary,
   input wire frameIsKnownUnicast,
   input wire frameIsMulticast,
   input wire frameIsBroadcast,
   input wire [10:0] frameLength,
   input wire [4:0] collisionCount,
   input wire egressContention,
   input wire forwardAllowed,
   input wire stormCount,
   input wire frameOversize,
   input wire retryFrame,
   input wire dropNonFlowControlled,
   input wire flowControlPort
);
   default clocking @(posedge clock); endclocking
   default disable iff (srst);
   // The first edge after release still shows reset values, hence the guard
   a_vlan_open: assert property (!$past(srst) && !$past(portVlanBoundary) |-> forwardAllowed)
      else $error("frame blocked without boundary");
   a_vlan_block: assert property (!$past(srst) && $past(portVlanBoundary)
      && !$past(frameIsKnownUnicast) |-> !forwardAllowed) else $error("frame crossed boundary");
   a_storm_bcast: assert property (!$past(srst) && $past(frameIsBroadcast) |-> stormCount)
      else $error("broadcast not counted");
   a_storm_none: assert property (!$past(srst) && !$past(frameIsBroadcast)
      && !$past(frameIsMulticast) |-> !stormCount) else $error("plain frame counted");
   a_retry_low: assert property (!$past(srst) && $past(collisionCount) < 5'h10 |-> retryFrame)
      else $error("retry refused below limit");
   a_size_small: assert property (!$past(srst) && $past(frameLength) <= 11'h5EE |-> !frameOversize)
      else $error("small frame oversize");
   a_size_huge: assert property (!$past(srst) && $past(frameLength) > 11'h77C |-> frameOversize)
      else $error("huge frame accepted");
   a_fair_split: assert property (!$past(srst) |-> !(dropNonFlowControlled && flowControlPort)
      && (dropNonFlowControlled || flowControlPort) == $past(egressContention)) else $error("bad fairness");
endmodule // switch_global_control_bits_props

bind switch_global_control_bits switch_global_control_bits_props switch_global_control_bits_props_i (.*);

// ### testbench/switch_global_control_bits_tb.sv
// Self-checking bench for the global control bits
`timescale 1ns/1ps
module switch_global_control_bits_tb;
   reg clock = 0, srst = 1, aging_strap_pin, backoff_strap_pin, collision_drop_strap_pin;
   reg [7:0] s_axi_awaddr = 0, s_axi_araddr = 0, c1, c2;
   reg [31:0] s_axi_wdata = 0, seed = 32'd15011;
   reg [3:0] s_axi_wstrb = 4'hF;
   reg s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0, s_axi_rready = 0;
   reg portVlanBoundary = 0, frameIsKnownUnicast = 0, frameIsMulticast = 0, frameIsBroadcast = 0;
   reg frameTagged = 0, egressContention = 0;
   reg [10:0] frameLength = 0, lim;
   reg [4:0] collisionCount = 0;
   wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   wire [1:0] s_axi_bresp, s_axi_rresp;
   wire [31:0] s_axi_rdata;
   wire agingRun, agingTick, aggressiveBackoff, carrierSenseBackpressure, forwardAllowed;
   wire stormCount, frameOversize, retryFrame, dropNonFlowControlled, flowControlPort;
   integer err_count = 0, compares = 0, i, j, ticks;
   reg [33:0] q[$];
   reg [8:0] ex;
   localparam [7:0] A1 = 8'h0C, A2 = 8'h10, AX = 8'h18;
   always #12.5 clock = ~clock;
   // Short age periods keep the run brief
   switch_global_control_bits #(.FAST_AGE_CYCLES(20), .NORMAL_AGE_CYCLES(100))
      switch_global_control_bits_i (.*);
   function [31:0] rnd();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      rnd = seed;
   endfunction
   task chk(input [33:0] e, input [33:0] g); begin
      compares = compares + 1;
      if (g !== e) begin
         err_count = err_count + 1;
         $display("Error t=%0t exp=%h got=%h", $time, e, g);
      end
   end endtask
   task give_verdict; begin
      $display("Compares %0d, errors %0d", compares, err_count);
      if (err_count == 0 && compares > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   end endtask
   // Upper data bits are random since the slave must ignore them
   task wr(input [7:0] a, input [7:0] d, input [1:0] r); begin
      q.push_back({r, 32'h0});
      @(posedge clock);
      s_axi_awaddr <= a;
      s_axi_wdata <= (rnd() & 32'hFFFFFF00) | d;
      s_axi_awvalid <= 1;
      s_axi_wvalid <= 1;
      s_axi_bready <= 1;
      do begin
         @(posedge clock);
         if (s_axi_awready) s_axi_awvalid <= 0;
         if (s_axi_wready) s_axi_wvalid <= 0;
      end while (!s_axi_bvalid);
      s_axi_bready <= 0;
   end endtask
   task rd(input [7:0] a, input [33:0] e); begin
      q.push_back(e);
      @(posedge clock);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1;
      s_axi_rready <= 1;
      do begin
         @(posedge clock);
         if (s_axi_arready) s_axi_arvalid <= 0;
      end while (!s_axi_rvalid);
      s_axi_rready <= 0;
   end endtask
   always @(posedge clock) begin
      if (s_axi_bvalid && s_axi_bready) chk(q.pop_front(), {s_axi_bresp, 32'h0});
      if (s_axi_rvalid && s_axi_rready) chk(q.pop_front(), {s_axi_rresp, s_axi_rdata});
   end
   initial begin
      #125000;
      err_count = err_count + 1;
      give_verdict;
   end
   initial begin
      {aging_strap_pin, backoff_strap_pin, collision_drop_strap_pin} = rnd() >> 5;
      repeat (20) @(posedge clock);
      srst <= 0;
      repeat (3) @(posedge clock);
      rd(A1, {5'h0, aging_strap_pin, 1'b0, backoff_strap_pin});
      rd(A2, {4'hF, collision_drop_strap_pin, 3'h0});
      for (i = 0; i < 12; i = i + 1) begin
         c1 = rnd() & 8'hFD;
         c2 = rnd();
         wr(A1, c1, 2'h0);
         rd(A1, c1);
         wr(A2, c2, 2'h0);
         rd(A2, c2);
         for (j = 0; j < 16; j = j + 1) begin
            @(posedge clock);
            {portVlanBoundary, frameIsKnownUnicast, frameIsMulticast} <= rnd();
            {frameIsBroadcast, frameTagged, egressContention, collisionCount} <= rnd();
            frameLength <= 11'h5EC + (rnd() & 11'h1FF);
            @(posedge clock);
            #1;
            lim = c2[2] ? 11'h77C : c2[1] ? 11'h600 : frameTagged ? 11'h5F2 : 11'h5EE;
            ex = {!portVlanBoundary | (!c2[7] & frameIsKnownUnicast),
               frameIsBroadcast | (frameIsMulticast & !c2[6]), frameLength > lim,
               collisionCount < 5'h10 | c2[3], egressContention & c2[4],
               egressContention & !c2[4], c1[0], c2[5], c1[2]};
            chk(ex, {forwardAllowed, stormCount, frameOversize, retryFrame, dropNonFlowControlled,
               flowControlPort, aggressiveBackoff, carrierSenseBackpressure, agingRun});
         end
      end
      // Fast bit must drop on its own once one short cycle has run
      wr(A1, 8'h06, 2'h0);
      ticks = 0;
      repeat (45) begin
         @(posedge clock);
         if (agingTick === 1'b1) ticks = ticks + 1;
      end
      // One short period ends, then the normal period of 100 cycles runs
      chk(34'h1, ticks);
      rd(A1, 34'h4);
      wr(AX, 8'h55, 2'h2);
      rd(AX, {2'h2, 32'h0});
      give_verdict;
   end
endmodule // switch_global_control_bits_tb
